/* File: shared/rdfp_if.sv */
// Interface carrying synchronised host strobes between modules
interface rdfp_if;
    logic sampleFall;
    logic sampleRise;
    logic readActive;
    logic selectPos;
    logic serialSel;
    modport producer (output sampleFall, sampleRise, readActive, selectPos, serialSel);
    modport consumer (input sampleFall, sampleRise, readActive, selectPos, serialSel);
endinterface

/* File: shared/rdfp_pkg.sv */
// Package of constants and types for the resolver fault and data port
package rdfp_pkg;
    localparam int DATA_W = 12;
    localparam int MON_W = 12;
    // Angle LSB of 12-bit word is 360/4096 degrees
    localparam int ANGLE_FULL = 4096;
    localparam int LOT_SET_DEG = 5;
    localparam int LOT_CLR_DEG = 1;
    localparam int DOS_ERR_DEG = 30;
    localparam logic [DATA_W-1:0] LOT_SET_LSB = DATA_W'((LOT_SET_DEG * ANGLE_FULL + 359) / 360);
    localparam logic [DATA_W-1:0] LOT_CLR_LSB = DATA_W'((LOT_CLR_DEG * ANGLE_FULL) / 360);
    localparam logic [DATA_W-1:0] DOS_ERR_LSB = DATA_W'((DOS_ERR_DEG * ANGLE_FULL) / 360);
    // Velocity word full scale corresponds to 1000 rps
    localparam logic [DATA_W-1:0] VEL_MAX = 12'h7FF;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [1:0] {RDFP_OK, RDFP_LOT, RDFP_DOS, RDFP_LOS} rdfp_fault_t;
endpackage

/* File: tb/rdfp_checker_properties.sv */
// Concurrent checks on the pins of the fault and data port
module rdfp_checker
#(
    parameter int DATA_W = 12,
    parameter int MON_W = 12
)
(
    // Clock and reset
    input logic clk,
    input logic reset_n,
    // Host pins
    input logic sample_n,
    input logic chipSel_n,
    input logic read_n,
    input logic serial_port_sel_n,
    // Loop and monitor
    input logic [DATA_W-1:0] loopError,
    input logic [MON_W-1:0] monitorMag,
    input logic [MON_W-1:0] monitorMaxLimit,
    input logic [MON_W-1:0] monitorMinLimit,
    // Outputs
    input logic signal_degraded_n,
    input logic tracking_lost_n,
    input logic [DATA_W-1:0] dataOe_n,
    input logic loopStepUp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pin sync plus output register
    localparam int LAT = 4;
    logic [DATA_W-1:0] errMag;
    logic lossShown;
    assign errMag = loopError[DATA_W-1] ? -loopError : loopError;
    assign lossShown = !signal_degraded_n && !tracking_lost_n;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_overrange_degrades: assert property ((monitorMag > monitorMaxLimit)[*3] |-> ##[0:LAT] !signal_degraded_n)
        else $error("degradation pin not low while over range");
    a_error_loses_track: assert property ((signal_degraded_n && errMag > 12'h039)[*3]
        |-> ##[0:LAT] (!tracking_lost_n || !signal_degraded_n))
        else $error("tracking pin not low on large loop error");
    a_loss_both_low: assert property ((monitorMag < monitorMinLimit)[*3] |-> ##[0:LAT] lossShown)
        else $error("signal loss not shown on both pins");
    a_loss_stays_latched: assert property ((lossShown && sample_n)[*8] |=> lossShown)
        else $error("signal loss released without sample rise");
    a_float_read_high: assert property (read_n[*6] |-> &dataOe_n)
        else $error("bus driven while read high");
    a_float_cs_high: assert property (chipSel_n[*6] |-> &dataOe_n)
        else $error("bus driven while chip select high");
    a_read_drives_bus: assert property ((!chipSel_n && !read_n && serial_port_sel_n)[*7]
        |-> !(|dataOe_n))
        else $error("bus not driven during parallel read");
    a_serial_low_float: assert property ((!serial_port_sel_n)[*7] |-> &dataOe_n[DATA_W-2:0])
        else $error("low data bits driven in serial mode");
    a_step_always_moves: assert property ($past(reset_n) |-> loopStepUp != $past(loopStepUp))
        else $error("loop step sense did not move");
    c_loss: cover property (lossShown);
    c_read: cover property (!(|dataOe_n));
    c_track: cover property (signal_degraded_n && !tracking_lost_n);
endmodule
bind rdfp_fault_port rdfp_checker #(.DATA_W(DATA_W), .MON_W(MON_W)) rdfp_checker_inst (
    .clk(clk), .reset_n(reset_n), .sample_n(sample_n), .chipSel_n(chipSel_n),
    .read_n(read_n), .serial_port_sel_n(serial_port_sel_n), .loopError(loopError),
    .monitorMag(monitorMag), .monitorMaxLimit(monitorMaxLimit),
    .monitorMinLimit(monitorMinLimit), .signal_degraded_n(signal_degraded_n),
    .tracking_lost_n(tracking_lost_n), .dataOe_n(dataOe_n), .loopStepUp(loopStepUp));

/* File: tb/rdfp_host_model.sv */
// Host processor model driving the sample, select and read pins
module rdfp_host_model
(
    // Clock
    input logic clk,
    // Host pins
    output logic sample_n,
    output logic chipSel_n,
    output logic read_n,
    output logic pos_vel_select,
    output logic serial_port_sel_n,
    // Data bus and fault pins
    input logic [11:0] dataOut,
    input logic [11:0] dataOe_n,
    input logic signal_degraded_n,
    input logic tracking_lost_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        sample_n = 1'b1;
        chipSel_n = 1'b1;
        read_n = 1'b1;
        pos_vel_select = 1'b1;
        serial_port_sel_n = 1'b1;
    end
    task automatic set_mode(input logic parallel);
        @(negedge clk);
        serial_port_sel_n = parallel;
    endtask
    task automatic pulse_sample();
        @(negedge clk);
        sample_n = 1'b0;
        repeat (8) @(negedge clk);
        sample_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // Word taken one clock after the top driver turns on
    task automatic read_word(input logic selPos, output logic [11:0] word,
        output logic [11:0] oe, output logic valid);
        int n;
        @(negedge clk);
        pos_vel_select = selPos;
        chipSel_n = 1'b0;
        read_n = 1'b0;
        n = 0;
        while (dataOe_n[11] !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        word = dataOut;
        oe = dataOe_n;
        // Any fault shown makes the word untrustworthy
        valid = signal_degraded_n && tracking_lost_n;
        repeat (4) @(negedge clk);
        read_n = 1'b1;
        chipSel_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking testbench for the resolver fault and data port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, sample_n, chipSel_n, read_n, pos_vel_select, serial_port_sel_n;
    logic signal_degraded_n, tracking_lost_n, loopStepUp, valid;
    logic [11:0] posIntegrator, velIntegrator, loopError, monitorMag, mismatchLimit;
    logic [11:0] monitorMaxLimit, monitorMinLimit, dataOut, dataOe_n, word, oe;
    int failures, n_compared;
    rdfp_fault_port rdfp_fault_port_inst (.clk(clk), .reset_n(reset_n), .sample_n(sample_n),
        .chipSel_n(chipSel_n), .read_n(read_n), .pos_vel_select(pos_vel_select),
        .serial_port_sel_n(serial_port_sel_n), .posIntegrator(posIntegrator),
        .velIntegrator(velIntegrator), .loopError(loopError), .monitorMag(monitorMag),
        .monitorMaxLimit(monitorMaxLimit), .monitorMinLimit(monitorMinLimit),
        .mismatchLimit(mismatchLimit), .signal_degraded_n(signal_degraded_n),
        .tracking_lost_n(tracking_lost_n), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .loopStepUp(loopStepUp));
    rdfp_host_model rdfp_host_model_inst (.clk(clk), .sample_n(sample_n),
        .chipSel_n(chipSel_n), .read_n(read_n), .pos_vel_select(pos_vel_select),
        .serial_port_sel_n(serial_port_sel_n), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .signal_degraded_n(signal_degraded_n), .tracking_lost_n(tracking_lost_n));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Pin latency is not fixed, so wait a bounded span for the encoding
    task automatic pins(input logic [1:0] exp);
        int n;
        n = 0;
        while ({signal_degraded_n, tracking_lost_n} !== exp && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check({10'h000, signal_degraded_n, tracking_lost_n}, {10'h000, exp});
    endtask
    task automatic stay(input logic [1:0] exp);
        repeat (12) @(negedge clk);
        check({10'h000, signal_degraded_n, tracking_lost_n}, {10'h000, exp});
    endtask
    task automatic t_read();
        posIntegrator = 12'hABC;
        velIntegrator = 12'hF23;
        rdfp_host_model_inst.pulse_sample();
        posIntegrator = 12'h123;
        rdfp_host_model_inst.read_word(1'b1, word, oe, valid);
        check(word, 12'hABC);
        check(oe, 12'h000);
        check({11'h000, valid}, 12'h000);
        rdfp_host_model_inst.read_word(1'b0, word, oe, valid);
        check(word, 12'hF23);
        pins(2'b10);
        rdfp_host_model_inst.set_mode(1'b0);
        rdfp_host_model_inst.read_word(1'b1, word, oe, valid);
        check(oe, 12'h7FF);
        rdfp_host_model_inst.set_mode(1'b1);
        posIntegrator = 12'hABC;
        pins(2'b11);
    endtask
    task automatic t_degrade();
        monitorMag = 12'hE00;
        pins(2'b01);
        monitorMag = 12'h800;
        pins(2'b11);
        mismatchLimit = 12'h100;
        rdfp_host_model_inst.pulse_sample();
        monitorMag = 12'h900;
        stay(2'b11);
        monitorMag = 12'h901;
        pins(2'b01);
        monitorMag = 12'h800;
        stay(2'b01);
        rdfp_host_model_inst.pulse_sample();
        pins(2'b11);
    endtask
    task automatic t_track();
        posIntegrator = 12'hAD0;
        stay(2'b11);
        loopError = 12'h03A;
        pins(2'b10);
        loopError = 12'hFE2;
        stay(2'b10);
        loopError = 12'h000;
        posIntegrator = 12'hABC;
        pins(2'b11);
        loopError = 12'hEAB;
        pins(2'b01);
        loopError = 12'h000;
        rdfp_host_model_inst.pulse_sample();
        pins(2'b11);
        velIntegrator = 12'h800;
        pins(2'b10);
        rdfp_host_model_inst.pulse_sample();
        rdfp_host_model_inst.read_word(1'b0, word, oe, valid);
        check(word, 12'h800);
        check({11'h000, valid}, 12'h000);
        velIntegrator = 12'h045;
        pins(2'b11);
    endtask
    task automatic t_loss();
        monitorMag = 12'h300;
        loopError = 12'h03A;
        pins(2'b00);
        monitorMag = 12'h800;
        loopError = 12'h000;
        stay(2'b00);
        rdfp_host_model_inst.pulse_sample();
        pins(2'b11);
        // Fresh start after a loss of signal
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check({10'h000, signal_degraded_n, tracking_lost_n}, 12'h003);
        check(dataOe_n, 12'hFFF);
        repeat (8) @(negedge clk);
        rdfp_host_model_inst.pulse_sample();
        rdfp_host_model_inst.read_word(1'b1, word, oe, valid);
        check(word, 12'hABC);
        check({11'h000, valid}, 12'h001);
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #100us;
        failures++;
        print_verdict();
    end
    initial
    begin
        failures = 0;
        n_compared = 0;
        reset_n = 1'b0;
        posIntegrator = 12'h000;
        velIntegrator = 12'h000;
        loopError = 12'h000;
        monitorMag = 12'h800;
        monitorMaxLimit = 12'hC00;
        monitorMinLimit = 12'h400;
        mismatchLimit = 12'h700;
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        check({10'h000, signal_degraded_n, tracking_lost_n}, 12'h003);
        check(dataOe_n, 12'hFFF);
        repeat (8) @(negedge clk);
        t_read();
        t_degrade();
        t_track();
        t_loss();
        print_verdict();
    end
endmodule

/* File: verilog/rdfp_fault_port.sv */
// Fault flag generation, holding registers and parallel data port
module rdfp_fault_port
#(
    parameter int DATA_W = rdfp_pkg::DATA_W,
    parameter int MON_W = rdfp_pkg::MON_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host pins
    input wire logic sample_n,
    input wire logic chipSel_n,
    input wire logic read_n,
    input wire logic pos_vel_select,
    input wire logic serial_port_sel_n,
    // Tracking loop state
    input wire logic [DATA_W-1:0] posIntegrator,
    input wire logic [DATA_W-1:0] velIntegrator,
    input wire logic [DATA_W-1:0] loopError,
    // Monitor magnitude and thresholds
    input wire logic [MON_W-1:0] monitorMag,
    input wire logic [MON_W-1:0] monitorMaxLimit,
    input wire logic [MON_W-1:0] monitorMinLimit,
    input wire logic [MON_W-1:0] mismatchLimit,
    // Fault pins
    output logic signal_degraded_n,
    output logic tracking_lost_n,
    // Data bus, enables active low
    output logic [DATA_W-1:0] dataOut,
    output logic [DATA_W-1:0] dataOe_n,
    // Loop error step sense for the tracking loop
    output logic loopStepUp
);
    // ==========================================================
    // Parameter checks
    if (DATA_W != 12)
    begin : g_bad_data_w
        $error("Data width must be 12");
    end
    if (MON_W < 2)
    begin : g_bad_mon_w
        $error("Monitor width too small");
    end
    // Hysteresis collapses if the clear level reaches the set level
    if (rdfp_pkg::LOT_CLR_LSB >= rdfp_pkg::LOT_SET_LSB)
    begin : g_bad_lot_levels
        $error("Tracking clear level must sit under set level");
    end
    if (rdfp_pkg::DOS_ERR_LSB <= rdfp_pkg::LOT_SET_LSB)
    begin : g_bad_dos_level
        $error("Degradation error level must exceed tracking level");
    end

    rdfp_if sync ();

    rdfp_pin_sync u_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .sample_n(sample_n),
        .chipSel_n(chipSel_n),
        .read_n(read_n),
        .pos_vel_select(pos_vel_select),
        .serial_port_sel_n(serial_port_sel_n),
        .sync(sync.producer)
    );

    // ==========================================================
    // Holding registers
    logic [DATA_W-1:0] posHold_q;
    logic [DATA_W-1:0] posHold_d;
    logic [DATA_W-1:0] velHold_q;
    logic [DATA_W-1:0] velHold_d;
    logic [DATA_W-1:0] outReg_q;
    logic [DATA_W-1:0] outReg_d;

    always_comb
    begin
        posHold_d = posHold_q;
        velHold_d = velHold_q;
        outReg_d = outReg_q;
        if (sync.sampleFall)
        begin
            posHold_d = posIntegrator;
            velHold_d = velIntegrator;
        end
        // Integrators are inputs, never stalled by reads
        if (sync.readActive)
        begin
            outReg_d = sync.selectPos ? posHold_q : velHold_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            posHold_q <= 12'h000;
            velHold_q <= 12'h000;
            outReg_q <= 12'h000;
        end
        else
        begin
            posHold_q <= posHold_d;
            velHold_q <= velHold_d;
            outReg_q <= outReg_d;
        end
    end

    // ==========================================================
    // Monitor min/max tracking
    logic [MON_W-1:0] monMin_q;
    logic [MON_W-1:0] monMin_d;
    logic [MON_W-1:0] monMax_q;
    logic [MON_W-1:0] monMax_d;
    logic losLatch_q;
    logic losLatch_d;
    logic mismatch_q;
    logic mismatch_d;

    always_comb
    begin
        monMin_d = monMin_q;
        monMax_d = monMax_q;
        losLatch_d = losLatch_q;
        mismatch_d = mismatch_q;
        if (monitorMag < monMin_q)
        begin
            monMin_d = monitorMag;
        end
        if (monitorMag > monMax_q)
        begin
            monMax_d = monitorMag;
        end
        if (monMax_q > monMin_q && (monMax_q - monMin_q) > mismatchLimit)
        begin
            mismatch_d = 1'b1;
        end
        if (monitorMag < monitorMinLimit)
        begin
            losLatch_d = 1'b1;
        end
        // Sample rise restarts the window; a new loss of signal still wins, a new mismatch is cleared
        if (sync.sampleRise)
        begin
            monMin_d = monitorMag;
            monMax_d = monitorMag;
            mismatch_d = 1'b0;
            losLatch_d = monitorMag < monitorMinLimit;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            monMin_q <= {MON_W{1'b1}};
            monMax_q <= {MON_W{1'b0}};
            losLatch_q <= 1'b0;
            mismatch_q <= 1'b0;
        end
        else
        begin
            monMin_q <= monMin_d;
            monMax_q <= monMax_d;
            losLatch_q <= losLatch_d;
            mismatch_q <= mismatch_d;
        end
    end

    // ==========================================================
    // Loss of tracking with hysteresis
    logic lot_q;
    logic lot_d;
    logic overspeed_q;
    logic overspeed_d;
    logic stepUp_q;
    logic stepUp_d;
    logic [DATA_W-1:0] errMag;
    logic [DATA_W-1:0] posDiff;
    logic [DATA_W-1:0] posMis;
    logic [DATA_W-1:0] velMag;
    logic overRange;
    logic overSpeedNow;
    logic dosErr;

    always_comb
    begin
        errMag = loopError[DATA_W-1] ? DATA_W'(-loopError) : loopError;
        posDiff = posIntegrator - posHold_q;
        posMis = posDiff[DATA_W-1] ? DATA_W'(-posDiff) : posDiff;
        velMag = velIntegrator[DATA_W-1] ? DATA_W'(-velIntegrator) : velIntegrator;
        overSpeedNow = velMag > rdfp_pkg::VEL_MAX
            || velIntegrator == 12'h800;
        overRange = monitorMag > monitorMaxLimit;
        // Large loop error also flags degradation, bounding error at 30 deg
        dosErr = errMag >= rdfp_pkg::DOS_ERR_LSB;
        lot_d = lot_q;
        overspeed_d = overspeed_q;
        if (overSpeedNow)
        begin
            lot_d = 1'b1;
            overspeed_d = 1'b1;
        end
        else if (errMag > rdfp_pkg::LOT_SET_LSB || posMis > rdfp_pkg::LOT_SET_LSB)
        begin
            lot_d = 1'b1;
        end
        else if (overspeed_q)
        begin
            if (posMis < rdfp_pkg::LOT_CLR_LSB)
            begin
                lot_d = 1'b0;
                overspeed_d = 1'b0;
            end
        end
        else if (errMag < rdfp_pkg::LOT_CLR_LSB && posMis < rdfp_pkg::LOT_CLR_LSB)
        begin
            lot_d = 1'b0;
        end
        // Keep the loop error moving one LSB every clock
        stepUp_d = !stepUp_q;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            lot_q <= 1'b0;
            overspeed_q <= 1'b0;
            stepUp_q <= 1'b0;
        end
        else
        begin
            lot_q <= lot_d;
            overspeed_q <= overspeed_d;
            stepUp_q <= stepUp_d;
        end
    end

    // ==========================================================
    // Fault encoder and pin registers
    rdfp_pkg::rdfp_fault_t fault;
    logic dosN_d;
    logic lotN_d;
    logic dosN_q;
    logic lotN_q;

    always_comb
    begin
        if (losLatch_q)
        begin
            fault = rdfp_pkg::RDFP_LOS;
        end
        else if (overRange || mismatch_q || dosErr)
        begin
            fault = rdfp_pkg::RDFP_DOS;
        end
        else if (lot_q)
        begin
            fault = rdfp_pkg::RDFP_LOT;
        end
        else
        begin
            fault = rdfp_pkg::RDFP_OK;
        end
        case (fault)
            rdfp_pkg::RDFP_LOS:
            begin
                dosN_d = 1'b0;
                lotN_d = 1'b0;
            end
            rdfp_pkg::RDFP_DOS:
            begin
                dosN_d = 1'b0;
                lotN_d = 1'b1;
            end
            rdfp_pkg::RDFP_LOT:
            begin
                dosN_d = 1'b1;
                lotN_d = 1'b0;
            end
            default:
            begin
                dosN_d = 1'b1;
                lotN_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            dosN_q <= 1'b1;
            lotN_q <= 1'b1;
        end
        else
        begin
            dosN_q <= dosN_d;
            lotN_q <= lotN_d;
        end
    end

    // ==========================================================
    // Data bus drivers
    logic [DATA_W-1:0] dOut_d;
    logic [DATA_W-1:0] dOut_q;
    logic [DATA_W-1:0] dOe_d;
    logic [DATA_W-1:0] dOe_q;

    always_comb
    begin
        // Data path ignores faults entirely
        dOut_d = outReg_d;
        dOe_d = {DATA_W{1'b1}};
        if (sync.readActive)
        begin
            if (sync.serialSel)
            begin
                dOe_d = {1'b0, {(DATA_W-1){1'b1}}};
            end
            else
            begin
                dOe_d = {DATA_W{1'b0}};
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            dOut_q <= 12'h000;
            dOe_q <= 12'hFFF;
        end
        else
        begin
            dOut_q <= dOut_d;
            dOe_q <= dOe_d;
        end
    end

    assign signal_degraded_n = dosN_q;
    assign tracking_lost_n = lotN_q;
    assign dataOut = dOut_q;
    assign dataOe_n = dOe_q;
    assign loopStepUp = stepUp_q;
endmodule

/* File: verilog/rdfp_pin_sync.sv */
// Three-stage synchronisers for host pins, with edge detection on the sample pin only
module rdfp_pin_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host pins
    input wire logic sample_n,
    input wire logic chipSel_n,
    input wire logic read_n,
    input wire logic pos_vel_select,
    input wire logic serial_port_sel_n,
    // Synchronised events
    rdfp_if.producer sync
);
    localparam int N = 5;
    logic [N-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, st_q, st_d;
    logic sampleFall_d, sampleRise_d, sampleFall_q, sampleRise_q;

    always_comb
    begin
        s1_d = {sample_n, chipSel_n, read_n, pos_vel_select, serial_port_sel_n};
        s2_d = s1_q;
        s3_d = s2_q;
        st_d = st_q;
        // Accept a change only when stages two and three agree
        for (int i = 0; i < N; i++)
        begin
            if (s2_q[i] == s3_q[i])
            begin
                st_d[i] = s3_q[i];
            end
        end
        sampleFall_d = st_q[4] && !st_d[4];
        sampleRise_d = !st_q[4] && st_d[4];
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s1_q <= 5'h1F;
            s2_q <= 5'h1F;
            s3_q <= 5'h1F;
            st_q <= 5'h1F;
            sampleFall_q <= 1'b0;
            sampleRise_q <= 1'b0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            st_q <= st_d;
            sampleFall_q <= sampleFall_d;
            sampleRise_q <= sampleRise_d;
        end
    end

    assign sync.sampleFall = sampleFall_q;
    assign sync.sampleRise = sampleRise_q;
    assign sync.readActive = !st_q[3] && !st_q[2];
    assign sync.selectPos = st_q[1];
    assign sync.serialSel = !st_q[0];
endmodule
